// file: rtl/apt_pkg.sv
// constants, field layouts and state types shared by the playback trigger controller
package apt_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam logic [7:0]  APT_OFS_CTRL    = 8'h00;    // control and mode settings
    localparam logic [7:0]  APT_OFS_DELAY   = 8'h04;    // external trigger delay, samples
    localparam logic [7:0]  APT_OFS_LENGTH  = 8'h08;    // waveform length, samples
    localparam logic [7:0]  APT_OFS_KEY     = 8'h0c;    // manual key trigger strobe
    localparam logic [7:0]  APT_OFS_STATUS  = 8'h10;    // playback status, read only

    // ------------------------------------------------------------
    // control register field positions
    // ------------------------------------------------------------
    localparam int APT_CTRL_ARB_ON    = 0;             // waveform output switched on
    localparam int APT_CTRL_LOADED    = 1;             // waveform data downloaded
    localparam int APT_CTRL_MODE_LO   = 2;             // playback_trigger_mode, 2 bits
    localparam int APT_CTRL_CONT_LO   = 4;             // continuous subtype, 2 bits
    localparam int APT_CTRL_SING_LO   = 6;             // one-shot subtype, 2 bits
    localparam int APT_CTRL_GATE_HIGH = 8;             // gate active high when set
    localparam int APT_CTRL_SRC_EXT   = 9;             // external trigger source
    localparam int APT_CTRL_SLOPE_NEG = 10;            // external trigger on falling edge
    localparam int APT_CTRL_DLY_EN    = 11;            // external delay applied
    localparam int APT_CTRL_WIDTH     = 12;            // implemented control bits

    // ------------------------------------------------------------
    // status and key register field positions
    // ------------------------------------------------------------
    localparam int APT_STAT_PLAYING   = 0;
    localparam int APT_STAT_PENDING   = 1;
    localparam int APT_STAT_DLY_BUSY  = 2;
    localparam int APT_STAT_GATE_ACT  = 3;
    localparam int APT_STAT_IDX_LO    = 16;
    localparam int APT_KEY_FIRE       = 0;             // key strobe bit

    // ------------------------------------------------------------
    // widths, reset values, limits
    // ------------------------------------------------------------
    localparam int                 APT_IDX_W      = 16;              // sample index width
    localparam int                 APT_FIFO_DEPTH = 8;               // index fifo depth
    localparam logic [31:0]        APT_DELAY_MAX  = 32'h9502f900;    // 2500000000 samples
    localparam logic [APT_CTRL_WIDTH-1:0] APT_CTRL_RST = 12'h000;    // all default modes
    localparam logic [31:0]        APT_DELAY_RST  = 32'h00000000;
    localparam logic [APT_IDX_W-1:0] APT_LENGTH_RST = 16'h0000;

    // ------------------------------------------------------------
    // mode and state encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        APT_MODE_CONT   = 2'b00,                       // continuous, reset default
        APT_MODE_SINGLE = 2'b01,                       // one-shot
        APT_MODE_GATE   = 2'b10                        // gated
    } apt_mode_t;

    typedef enum logic [1:0] {
        APT_CONT_FREE    = 2'b00,                      // free running, reset default
        APT_CONT_TRIG    = 2'b01,                      // trigger started
        APT_CONT_RESTART = 2'b10                       // restart on retrigger
    } apt_cont_t;

    typedef enum logic [1:0] {
        APT_SING_DROP    = 2'b00,                      // drop retriggers, reset default
        APT_SING_QUEUE   = 2'b01,                      // queue one retrigger
        APT_SING_RESTART = 2'b10                       // restart on retrigger
    } apt_sing_t;

    typedef enum logic [1:0] {
        APT_ST_IDLE = 2'b00,                           // no output, waiting
        APT_ST_PLAY = 2'b01                            // emitting sample indices
    } apt_state_t;

endpackage

// file: rtl/apt_fifo.sv
// small synchronous fifo with valid/ready on both sides and a flush input
`timescale 1ns/1ps
`default_nettype none

module apt_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;              // storage words
        logic [AW-1:0]               wr_ptr;           // next write slot
        logic [AW-1:0]               rd_ptr;           // next read slot
        logic [AW:0]                 count;            // words held
    } apt_fifo_t;

    apt_fifo_t r_ff;
    apt_fifo_t nxt_r;
    logic      push;
    logic      pop;

    assign in_ready  = (r_ff.count != DEPTH[AW:0]);
    assign out_valid = (r_ff.count != '0);
    assign out_data  = r_ff.mem[r_ff.rd_ptr];          // straight from storage flops
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // next state: flush empties, otherwise push and pop together
    always_comb
    begin
        nxt_r = r_ff;
        if (flush)
        begin
            nxt_r.wr_ptr = '0;
            nxt_r.rd_ptr = '0;
            nxt_r.count  = '0;
        end
        else
        begin
            if (push)
            begin
                nxt_r.mem[r_ff.wr_ptr] = in_data;
                nxt_r.wr_ptr = r_ff.wr_ptr + 1'b1;
            end
            if (pop)
                nxt_r.rd_ptr = r_ff.rd_ptr + 1'b1;
            nxt_r.count = r_ff.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

endmodule

`default_nettype wire

// file: rtl/apt_ctrl.sv
// waveform playback trigger controller with apb registers and index fifo
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - three modes: continuous, one-shot, gated; continuous default
// - continuous repeats sequence after accepted trigger
// - one-shot plays sequence once per trigger
// - gated plays while gate active, halts otherwise
// - free-running starts on download, ignores triggers
// - trigger-started waits for trigger, then ignores triggers
// - restart subtype restarts from first sample
// - gate level selectable, active-low by default
// - drop subtype discards triggers during a pass
// - queue subtype replays once for remembered trigger
// - one-shot restart aborts pass, starts fresh
// - trigger from key or external; key default
// - external edge polarity selectable, positive default
// - external delay programmable zero to maximum count
// - delay applied only while delay enable set
module apt_ctrl (
    input  wire logic        clk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // trigger side
    input  wire logic        ext_trig,
    input  wire logic        gate_in,
    // sample index stream
    output logic      [15:0] sample_idx,
    output logic             sample_valid,
    input  wire logic        sample_ready,
    output logic             playing
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_ff;                                 // first synchroniser stage
    logic rst_n_ff;                                    // released reset for the block

    // two flops so release is clean with respect to clk
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [apt_pkg::APT_CTRL_WIDTH-1:0] ctrl;      // control register
        logic [31:0]                  delay;           // external delay in samples
        logic [apt_pkg::APT_IDX_W-1:0] length;         // samples per pass
        logic                         key_pulse;       // manual trigger strobe
        logic                         ext_q;           // last raw ext pin level
        logic                         dly_busy;        // delay countdown running
        logic [31:0]                  dly_cnt;         // remaining delay samples
        apt_pkg::apt_state_t          state;           // playback state
        logic [apt_pkg::APT_IDX_W-1:0] idx;            // next sample index
        logic                         pending;         // queued trigger
        logic [31:0]                  rdata;           // apb read data
    } apt_ctrl_t;

    apt_ctrl_t r_ff;
    apt_ctrl_t nxt_r;

    // ------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------
    logic                arb_on;
    logic                loaded;
    apt_pkg::apt_mode_t  mode;
    apt_pkg::apt_cont_t  cont_type;
    apt_pkg::apt_sing_t  sing_type;
    logic                gate_high;
    logic                src_ext;
    logic                slope_neg;
    logic                dly_en;

    assign arb_on    = r_ff.ctrl[apt_pkg::APT_CTRL_ARB_ON];
    assign loaded    = r_ff.ctrl[apt_pkg::APT_CTRL_LOADED];
    assign mode      = apt_pkg::apt_mode_t'(r_ff.ctrl[apt_pkg::APT_CTRL_MODE_LO +: 2]);
    assign cont_type = apt_pkg::apt_cont_t'(r_ff.ctrl[apt_pkg::APT_CTRL_CONT_LO +: 2]);
    assign sing_type = apt_pkg::apt_sing_t'(r_ff.ctrl[apt_pkg::APT_CTRL_SING_LO +: 2]);
    assign gate_high = r_ff.ctrl[apt_pkg::APT_CTRL_GATE_HIGH];
    assign src_ext   = r_ff.ctrl[apt_pkg::APT_CTRL_SRC_EXT];
    assign slope_neg = r_ff.ctrl[apt_pkg::APT_CTRL_SLOPE_NEG];
    assign dly_en    = r_ff.ctrl[apt_pkg::APT_CTRL_DLY_EN];

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic        ext_lvl;                              // ext level after polarity
    logic        ext_edge;                             // selected edge seen
    logic        ext_fire;                             // external trigger accepted
    logic        trig;                                 // trigger from selected source
    logic        gate_act;                             // gate at its active level
    logic        can_run;                              // waveform ready and enabled
    logic        last;                                 // index is final sample
    logic        wr_en;                                // apb write this cycle
    logic        mapped;                               // address decodes
    logic        flush;                                // drop queued indices
    logic        push;                                 // offer index to fifo
    logic        fifo_in_ready;                        // fifo has room
    logic [31:0] rd_mux;                               // read data selection
    logic [31:0] status;                               // status word

    assign ext_lvl  = ext_trig ^ slope_neg;
    // previous level judged under today's polarity, so a slope change is no edge
    assign ext_edge = ext_lvl & ~(r_ff.ext_q ^ slope_neg);
    assign gate_act = (gate_in == gate_high);
    assign can_run  = arb_on & loaded & (r_ff.length != '0);
    assign last     = (r_ff.idx == r_ff.length - 1'b1);
    assign wr_en    = psel & penable & pwrite;
    assign playing  = (r_ff.state == apt_pkg::APT_ST_PLAY);

    // ------------------------------------------------------------
    // apb slave: zero wait states, read data latched in setup
    // ------------------------------------------------------------
    always_comb
    begin
        status = '0;
        status[apt_pkg::APT_STAT_PLAYING]  = playing;
        status[apt_pkg::APT_STAT_PENDING]  = r_ff.pending;
        status[apt_pkg::APT_STAT_DLY_BUSY] = r_ff.dly_busy;
        status[apt_pkg::APT_STAT_GATE_ACT] = gate_act;
        status[apt_pkg::APT_STAT_IDX_LO +: apt_pkg::APT_IDX_W] = r_ff.idx;
        mapped = 1'b1;
        rd_mux = '0;
        case (paddr)
            apt_pkg::APT_OFS_CTRL:   rd_mux[apt_pkg::APT_CTRL_WIDTH-1:0] = r_ff.ctrl;
            apt_pkg::APT_OFS_DELAY:  rd_mux = r_ff.delay;
            apt_pkg::APT_OFS_LENGTH: rd_mux[apt_pkg::APT_IDX_W-1:0] = r_ff.length;
            apt_pkg::APT_OFS_KEY:    rd_mux = '0;      // strobe reads as zero
            apt_pkg::APT_OFS_STATUS: rd_mux = status;
            default:                 mapped = 1'b0;    // unmapped reads zero, error
        endcase
    end

    assign prdata  = r_ff.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_r           = r_ff;
        nxt_r.key_pulse = 1'b0;
        nxt_r.ext_q     = ext_trig;
        ext_fire        = 1'b0;
        flush           = 1'b0;
        push            = 1'b0;

        // register writes and read capture
        if (psel & ~penable)
            nxt_r.rdata = rd_mux;
        if (wr_en)
        begin
            case (paddr)
                apt_pkg::APT_OFS_CTRL:
                    nxt_r.ctrl = pwdata[apt_pkg::APT_CTRL_WIDTH-1:0];
                apt_pkg::APT_OFS_DELAY:
                    // out of range values saturate at the maximum count
                    nxt_r.delay = (pwdata > apt_pkg::APT_DELAY_MAX) ?
                                  apt_pkg::APT_DELAY_MAX : pwdata;
                apt_pkg::APT_OFS_LENGTH:
                    nxt_r.length = pwdata[apt_pkg::APT_IDX_W-1:0];
                apt_pkg::APT_OFS_KEY:
                    nxt_r.key_pulse = pwdata[apt_pkg::APT_KEY_FIRE];
                default:
                    nxt_r.length = r_ff.length;        // unmapped write ignored
            endcase
        end

        // external trigger with optional sample delay
        if (r_ff.dly_busy)
        begin
            // edges arriving while a delay runs are dropped
            if (r_ff.dly_cnt == 32'h00000001)
            begin
                nxt_r.dly_busy = 1'b0;
                ext_fire       = 1'b1;
            end
            nxt_r.dly_cnt = r_ff.dly_cnt - 32'h00000001;
        end
        else if (ext_edge & src_ext)
        begin
            if (dly_en && (r_ff.delay != '0))
            begin
                nxt_r.dly_busy = 1'b1;
                nxt_r.dly_cnt  = r_ff.delay;
            end
            else
                ext_fire = 1'b1;
        end
        trig = src_ext ? ext_fire : r_ff.key_pulse;

        // playback control
        if (!can_run)
        begin
            // switched off or nothing loaded: stop and rewind
            nxt_r.state   = apt_pkg::APT_ST_IDLE;
            nxt_r.idx     = '0;
            nxt_r.pending = 1'b0;
            flush         = playing;
        end
        else
        begin
            case (mode)
                apt_pkg::APT_MODE_CONT:
                begin
                    case (cont_type)
                        apt_pkg::APT_CONT_FREE:
                            nxt_r.state = apt_pkg::APT_ST_PLAY;
                        apt_pkg::APT_CONT_TRIG:
                            if (!playing && trig)
                                nxt_r.state = apt_pkg::APT_ST_PLAY;
                        apt_pkg::APT_CONT_RESTART:
                        begin
                            if (!playing && trig)
                                nxt_r.state = apt_pkg::APT_ST_PLAY;
                            else if (playing && trig)
                            begin
                                nxt_r.idx = '0;
                                flush     = 1'b1;
                            end
                        end
                        default:
                            nxt_r.state = apt_pkg::APT_ST_IDLE;
                    endcase
                end
                apt_pkg::APT_MODE_SINGLE:
                begin
                    if (!playing && trig)
                        nxt_r.state = apt_pkg::APT_ST_PLAY;
                    else if (playing && trig)
                    begin
                        case (sing_type)
                            apt_pkg::APT_SING_QUEUE:
                                nxt_r.pending = 1'b1;
                            apt_pkg::APT_SING_RESTART:
                            begin
                                nxt_r.idx = '0;
                                flush     = 1'b1;
                            end
                            default:
                                nxt_r.pending = r_ff.pending;
                        endcase
                    end
                end
                apt_pkg::APT_MODE_GATE:
                    // inactive gate halts and holds the index
                    nxt_r.state = gate_act ? apt_pkg::APT_ST_PLAY :
                                             apt_pkg::APT_ST_IDLE;
                default:
                    nxt_r.state = apt_pkg::APT_ST_IDLE;
            endcase

            // emit the next index unless restarting or gated off
            if (playing && !flush && ((mode != apt_pkg::APT_MODE_GATE) || gate_act))
            begin
                push = 1'b1;
                if (fifo_in_ready)
                begin
                    if (last)
                    begin
                        nxt_r.idx = '0;
                        if (mode == apt_pkg::APT_MODE_SINGLE)
                        begin
                            // a trigger queued this very cycle still counts
                            if (nxt_r.pending)
                                nxt_r.pending = 1'b0;
                            else
                                nxt_r.state = apt_pkg::APT_ST_IDLE;
                        end
                    end
                    else
                        nxt_r.idx = r_ff.idx + 1'b1;
                end
            end
            if (mode != apt_pkg::APT_MODE_SINGLE)
                nxt_r.pending = 1'b0;                  // queue only meaningful in one-shot
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            r_ff        <= '0;
            r_ff.ctrl   <= apt_pkg::APT_CTRL_RST;
            r_ff.delay  <= apt_pkg::APT_DELAY_RST;
            r_ff.length <= apt_pkg::APT_LENGTH_RST;
            r_ff.state  <= apt_pkg::APT_ST_IDLE;
        end
        else
            r_ff <= nxt_r;
    end

    // ------------------------------------------------------------
    // index fifo towards the sample reader
    // ------------------------------------------------------------
    apt_fifo #(
        .WIDTH (apt_pkg::APT_IDX_W),
        .DEPTH (apt_pkg::APT_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n_ff),
        .flush     (flush),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (r_ff.idx),
        .out_valid (sample_valid),
        .out_ready (sample_ready),
        .out_data  (sample_idx)
    );

endmodule

`default_nettype wire

// file: verification/apt_ctrl_checker.sv
// port-level assertions for the playback trigger controller
`timescale 1ns/1ps
`default_nettype none
module apt_ctrl_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] sample_idx,
    input wire logic        sample_valid,
    input wire logic        sample_ready,
    input wire logic        playing
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_access: assert property (pslverr |-> psel && penable) else $error("stray error");
    chk_unmapped_err:
        assert property (psel && penable && paddr > 8'h10 |-> pslverr) else $error("no error");
    chk_mapped_ok:
        assert property (psel && paddr[1:0] == 2'b00 && paddr <= 8'h10 |-> !pslverr)
        else $error("error on mapped register");
    chk_rdata_hold:
        assert property ($changed(prdata) |-> $past(psel) && !$past(penable))
        else $error("read data moved outside setup");
    chk_stream_hold:
        assert property (sample_valid && !sample_ready |=> !sample_valid || $stable(sample_idx))
        else $error("index changed under stall");
    chk_start_push:
        assert property ($rose(playing) |-> ##[1:3] sample_valid) else $error("no index offered");
    chk_first_idx:
        assert property ($rose(playing) && !sample_valid |=> ##[0:2] (sample_valid && sample_idx == 16'h0000))
        else $error("pass not from index zero");
    cover property ($rose(playing));
    cover property (pslverr);
    cover property (sample_valid && !sample_ready);
endmodule
bind apt_ctrl apt_ctrl_checker i_apt_ctrl_checker (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_idx(sample_idx), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .playing(playing));
`default_nettype wire

// file: verification/apt_trig_src.sv
// far-side model: external trigger line and gate line
`timescale 1ns/1ps
`default_nettype none
module apt_trig_src (
    input wire logic clk,
    output logic     ext_trig,
    output logic     gate_in
);
    // lines start idle, gate at the inactive level of the active-low default
    initial
    begin
        ext_trig = 1'b0;
        gate_in = 1'b1;
    end
    // quiet level for three cycles, then one edge of the chosen polarity
    task pulse(input logic neg);
        @(posedge clk);
        ext_trig <= neg;
        repeat (3) @(posedge clk);
        ext_trig <= ~neg;
        @(posedge clk);
    endtask
    // gate held at the given level until changed
    task gate(input logic lvl);
        @(posedge clk);
        gate_in <= lvl;
    endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the playback trigger controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] a_ctl = apt_pkg::APT_OFS_CTRL;
    localparam logic [7:0] a_dly = apt_pkg::APT_OFS_DELAY;
    localparam logic [7:0] a_key = apt_pkg::APT_OFS_KEY;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic ext_trig, gate_in, sample_valid, sample_ready, playing;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] sample_idx;
    int errors, check_count, cyc, starts, s0;
    apt_ctrl i_apt_ctrl (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_trig(ext_trig), .gate_in(gate_in), .sample_idx(sample_idx),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .playing(playing));
    apt_trig_src i_apt_trig_src (.clk(clk), .ext_trig(ext_trig), .gate_in(gate_in));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang limit, and a count of passes begun downstream
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sample_valid && sample_ready && sample_idx === 16'h0000) starts <= starts + 1;
        if (cyc == 3000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready; data and error taken at that edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        sample_ready = 1'b1;
        resetn = 1'b0;
        void'($urandom(63));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        apb(0, a_ctl, 0);
        chk(q, 32'h0);
        apb(0, 8'h40, 0);
        chk({31'h0, err}, 32'h1);
        apb(1, a_dly, 32'hffffffff);
        apb(0, a_dly, 0);
        chk(q, apt_pkg::APT_DELAY_MAX);
        // free running, random length, consumer stalling at random
        apb(1, apt_pkg::APT_OFS_LENGTH, 32'd4 + $urandom % 8);
        s0 = starts;
        apb(1, a_ctl, 32'h3);
        repeat (80) @(posedge clk) sample_ready <= 1'($urandom % 2);
        @(posedge clk) sample_ready <= 1'b1;
        chk(starts - s0 > 1, 1);
        apb(1, a_ctl, 0);
        apb(1, a_ctl, 32'h13);
        repeat (8) @(posedge clk);
        chk(playing, 0);
        apb(1, a_key, 1);
        repeat (4) @(posedge clk);
        chk(playing, 1);
        // one-shot drop, queue, restart: three keys each, one more pass per subtype
        apb(1, apt_pkg::APT_OFS_LENGTH, 32'd16);
        // continuous restart: a second key rewinds long before the pass ends
        apb(1, a_ctl, 0);
        apb(1, a_ctl, 32'h23);
        s0 = starts;
        repeat (2) apb(1, a_key, 1);
        repeat (6) @(posedge clk);
        chk(starts - s0, 2);
        for (int s = 0; s < 3; s++)
        begin
            apb(1, a_ctl, 0);
            apb(1, a_ctl, 32'h7 | s << 6);
            s0 = starts;
            repeat (3) apb(1, a_key, 1);
            repeat (60) @(posedge clk);
            chk(starts - s0, s + 1);
            chk(playing, 0);
        end
        // falling external edge delayed by eight samples
        apb(1, a_ctl, 0);
        apb(1, a_dly, 32'd8);
        apb(1, a_ctl, 32'he07);
        i_apt_trig_src.pulse(1'b1);
        repeat (7) @(posedge clk);
        chk(playing, 0);
        repeat (6) @(posedge clk);
        chk(playing, 1);
        // gate active low, then halted, then active high
        apb(1, a_ctl, 0);
        i_apt_trig_src.gate(1'b0);
        apb(1, a_ctl, 32'hb);
        repeat (6) @(posedge clk);
        chk(sample_valid, 1);
        i_apt_trig_src.gate(1'b1);
        repeat (12) @(posedge clk);
        chk(sample_valid, 0);
        apb(1, a_ctl, 0);
        apb(1, a_ctl, 32'h10b);
        repeat (6) @(posedge clk);
        chk(sample_valid, 1);
        tally_and_finish;
    end
endmodule
`default_nettype wire
